// ---- src/paf_port_access_filter.sv ----
// Ingress source-learning cap and port authorization gate, 26 ports.
// Assumes a Wishbone classic master and frame decisions on clk_i.
`timescale 1ns/1ps
module paf_port_access_filter #(
   parameter int unsigned SEC_CYCLES = paf_pkg::SEC_CYCLES
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [7:0]               wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic [paf_pkg::NPORT-1:0] link_up_i,
   input  wire logic                     frm_valid_i,
   input  wire logic [4:0]               frm_port_i,
   input  wire logic [2:0]               frm_kind_i,
   input  wire logic                     frm_sa_known_i,
   output logic                          dec_valid_o,
   output logic      [4:0]               dec_port_o,
   output logic                          dec_fwd_o,
   output logic                          dec_learn_o,
   output logic                          dec_to_srv_o,
   input  wire logic                     eg_valid_i,
   input  wire logic [4:0]               eg_port_i,
   input  wire logic                     eg_eapol_i,
   output logic                          eg_valid_o,
   output logic                          eg_pass_o,
   input  wire logic                     age_valid_i,
   input  wire logic [4:0]               age_port_i,
   input  wire logic                     srv_valid_i,
   input  wire logic [4:0]               srv_port_i,
   input  wire logic [1:0]               srv_kind_i,
   output logic                          cli_valid_o,
   output logic      [4:0]               cli_port_o,
   output logic      [paf_pkg::NPORT-1:0] id_req_o,
   output logic      [paf_pkg::NPORT-1:0] srv_retx_o
);
   localparam int unsigned NP = paf_pkg::NPORT;

   logic                cap_en_r;
   logic                auth_en_r;
   logic [7:0]          txper_r;
   logic [3:0]          maxreq_r;
   logic [4:0]          psel_r;
   logic [6:0]          cap_r    [NP];
   logic                lrndis_r [NP];
   paf_pkg::paf_mode_t  mode_r   [NP];
   logic [6:0]          cnt_r    [NP];
   logic [NP-1:0]       link_s1_r;
   logic [NP-1:0]       link_s2_r;
   logic [25:0]         pre_r;
   logic                tick_r;
   logic [NP-1:0]       auth_v;
   logic [NP-1:0]       idreq_v;
   logic [NP-1:0]       retx_v;
   paf_pkg::paf_ast_t   st_v     [NP];

   // Port number to array index; out-of-range ports fall back to 0
   function automatic logic [4:0] pidx(input logic [4:0] p);
      if (p >= 5'h01 && p <= 5'(NP))
         return p - 5'h01;
      return 5'h00;
   endfunction

   function automatic logic pok(input logic [4:0] p);
      return (p >= 5'h01 && p <= 5'(NP));
   endfunction

   // Link pins come from the PHY side
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         link_s1_r <= '0;
         link_s2_r <= '0;
      end
      else
      begin
         link_s1_r <= link_up_i;
         link_s2_r <= link_s1_r;
      end
   end

   // One-second tick for the resend timers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pre_r  <= 26'h0000000;
         tick_r <= 1'b0;
      end
      else if (pre_r == 26'(SEC_CYCLES - 1))
      begin
         pre_r  <= 26'h0000000;
         tick_r <= 1'b1;
      end
      else
      begin
         pre_r  <= pre_r + 26'h0000001;
         tick_r <= 1'b0;
      end
   end

   // Wishbone slave, ack one cycle after the strobe
   logic       wb_req;
   logic       wb_wr;
   logic [4:0] sidx;
   logic       sok;
   logic [6:0] scap;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr  = wb_req && wb_we_i;
   assign sidx   = pidx(psel_r);
   assign sok    = pok(psel_r);
   assign scap   = cap_r[sidx];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cap_en_r  <= 1'b0;
         auth_en_r <= 1'b0;
         txper_r   <= paf_pkg::TXPER_RST;
         maxreq_r  <= paf_pkg::MAXREQ_RST;
         psel_r    <= paf_pkg::PSEL_RST;
      end
      else if (wb_wr && wb_sel_i[0])
      begin
         unique case (wb_adr_i)
            paf_pkg::A_CTRL:
            begin
               cap_en_r  <= wb_dat_i[paf_pkg::CTRL_CAP];
               auth_en_r <= wb_dat_i[paf_pkg::CTRL_AUTH];
            end
            paf_pkg::A_TXPER:  txper_r  <= wb_dat_i[7:0];
            paf_pkg::A_MAXREQ: maxreq_r <= wb_dat_i[3:0];
            paf_pkg::A_PSEL:   psel_r   <= wb_dat_i[4:0];
            default: ;
         endcase
      end
   end

   // Per-port configuration through the port window
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int p = 0; p < NP; p++)
         begin
            cap_r[p]    <= paf_pkg::CAP_RST;
            lrndis_r[p] <= 1'b0;
            mode_r[p]   <= paf_pkg::MODE_RST;
         end
      end
      else if (wb_wr && sok && wb_adr_i == paf_pkg::A_PCFG)
      begin
         if (wb_sel_i[0] && wb_dat_i[6:0] <= paf_pkg::CAP_MAX)
         begin
            cap_r[sidx]    <= wb_dat_i[6:0];
            lrndis_r[sidx] <= wb_dat_i[paf_pkg::CFG_LRNDIS];
         end
         if (wb_sel_i[1])
            mode_r[sidx] <= paf_pkg::paf_mode_t'(wb_dat_i[paf_pkg::CFG_MODE +: 2]);
      end
   end

   logic [31:0] rd;
   always_comb
   begin
      rd = 32'h00000000;
      unique case (wb_adr_i)
         paf_pkg::A_CTRL:
         begin
            rd[paf_pkg::CTRL_CAP]  = cap_en_r;
            rd[paf_pkg::CTRL_AUTH] = auth_en_r;
         end
         paf_pkg::A_TXPER:  rd[7:0] = txper_r;
         paf_pkg::A_MAXREQ: rd[3:0] = maxreq_r;
         paf_pkg::A_PSEL:   rd[4:0] = psel_r;
         paf_pkg::A_PCFG:
            if (sok)
            begin
               rd[6:0]                    = scap;
               rd[paf_pkg::CFG_LRNDIS]    = lrndis_r[sidx];
               rd[paf_pkg::CFG_MODE +: 2] = mode_r[sidx];
            end
         paf_pkg::A_PSTAT:
            if (sok)
            begin
               rd[6:0]                  = cnt_r[sidx];
               rd[paf_pkg::ST_FULL]     = cap_en_r && scap != 7'h00
                                          && cnt_r[sidx] >= scap;
               rd[paf_pkg::ST_AUTH]     = auth_v[sidx];
               rd[paf_pkg::ST_LINK]     = link_s2_r[sidx];
               rd[paf_pkg::ST_FSM +: 2] = st_v[sidx];
            end
         default: rd = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h00000000;
      else if (wb_req && !wb_we_i)
         wb_dat_o <= rd;
   end

   // Ingress decision
   logic               fok;
   logic [4:0]         fi;
   paf_pkg::paf_mode_t fmode;
   logic               fctl;
   logic               fauto;
   logic               fpass;
   logic               fcapped;
   logic               ffull;
   logic               fwd;
   logic               learn;
   logic               to_srv;

   assign fok     = frm_valid_i && pok(frm_port_i);
   assign fi      = pidx(frm_port_i);
   assign fmode   = mode_r[fi];
   assign fctl    = auth_en_r && fmode != paf_pkg::PAF_NO_AUTH;
   assign fauto   = fctl && fmode == paf_pkg::PAF_PORT_AUTH_AUTOMATIC_SETTING;
   assign fpass   = !fctl || auth_v[fi];
   assign fcapped = cap_en_r && cap_r[fi] != 7'h00;
   assign ffull   = cnt_r[fi] >= cap_r[fi];

   always_comb
   begin
      fwd    = 1'b0;
      learn  = 1'b0;
      to_srv = 1'b0;
      if (frm_kind_i != paf_pkg::FK_DATA)
         to_srv = fauto && frm_kind_i == paf_pkg::FK_EAP;
      else if (!fpass)
         fwd = 1'b0;
      else if (frm_sa_known_i)
         fwd = 1'b1;
      else if (lrndis_r[fi])
         fwd = !fcapped;
      else if (fcapped && ffull)
         fwd = 1'b0;
      else
      begin
         learn = cnt_r[fi] != paf_pkg::CNT_SAT;
         fwd   = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dec_valid_o  <= 1'b0;
         dec_port_o   <= 5'h00;
         dec_fwd_o    <= 1'b0;
         dec_learn_o  <= 1'b0;
         dec_to_srv_o <= 1'b0;
      end
      else
      begin
         dec_valid_o  <= fok;
         dec_port_o   <= frm_port_i;
         dec_fwd_o    <= fok && fwd;
         dec_learn_o  <= fok && learn;
         dec_to_srv_o <= fok && to_srv;
      end
   end

   // Learned-entry count per port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int p = 0; p < NP; p++)
            cnt_r[p] <= 7'h00;
      end
      else
      begin
         for (int p = 0; p < NP; p++)
         begin
            logic inc;
            logic dec;
            inc = fok && learn && fi == 5'(p);
            dec = age_valid_i && pok(age_port_i) && pidx(age_port_i) == 5'(p)
                  && cnt_r[p] != 7'h00;
            if (inc && !dec)
               cnt_r[p] <= cnt_r[p] + 7'h01;
            else if (dec && !inc)
               cnt_r[p] <= cnt_r[p] - 7'h01;
         end
      end
   end

   // Egress gate
   logic [4:0] ei;
   logic       ectl;
   assign ei   = pidx(eg_port_i);
   assign ectl = auth_en_r && mode_r[ei] != paf_pkg::PAF_NO_AUTH;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         eg_valid_o <= 1'b0;
         eg_pass_o  <= 1'b0;
      end
      else
      begin
         eg_valid_o <= eg_valid_i && pok(eg_port_i);
         eg_pass_o  <= eg_valid_i && pok(eg_port_i)
                       && (eg_eapol_i || !ectl || auth_v[ei]);
      end
   end

   // Server answers rewrapped toward the client
   logic [4:0] si;
   logic       sv;
   assign si = pidx(srv_port_i);
   assign sv = srv_valid_i && pok(srv_port_i) && auth_en_r
               && mode_r[si] == paf_pkg::PAF_PORT_AUTH_AUTOMATIC_SETTING;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cli_valid_o <= 1'b0;
         cli_port_o  <= 5'h00;
      end
      else
      begin
         cli_valid_o <= sv;
         cli_port_o  <= srv_port_i;
      end
   end

   // One authenticator per port
   for (genvar g = 0; g < NP; g++)
   begin : g_port
      paf_auth_if pif();
      logic here;
      logic shere;
      assign here           = fok && fi == 5'(g);
      assign shere          = sv && si == 5'(g);
      assign pif.tick       = tick_r;
      assign pif.en         = auth_en_r;
      assign pif.link_up    = link_s2_r[g];
      assign pif.mode       = mode_r[g];
      assign pif.tx_period  = txper_r;
      assign pif.max_req    = maxreq_r;
      assign pif.ev_start   = here && frm_kind_i == paf_pkg::FK_START;
      assign pif.ev_logoff  = here && frm_kind_i == paf_pkg::FK_LOGOFF;
      assign pif.ev_eap     = here && frm_kind_i == paf_pkg::FK_EAP;
      assign pif.srv_accept = shere && srv_kind_i == paf_pkg::SK_ACCEPT;
      assign pif.srv_reject = shere && srv_kind_i == paf_pkg::SK_REJECT;
      assign auth_v[g]      = pif.authorized;
      assign idreq_v[g]     = pif.id_req;
      assign retx_v[g]      = pif.retx;
      assign st_v[g]        = pif.state;
      paf_auth_port u_fsm (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .pif   (pif)
      );
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         id_req_o   <= '0;
         srv_retx_o <= '0;
      end
      else
      begin
         id_req_o   <= idreq_v;
         srv_retx_o <= retx_v;
      end
   end
endmodule

// ---- src/paf_pkg.sv ----
// Constants and types of the port access filter.
// Assumes a 40 MHz clock and Wishbone byte addressing.
package paf_pkg;
   localparam int unsigned NPORT      = 26;
   localparam int unsigned PW         = 5;
   localparam logic [6:0]  CAP_MAX    = 7'h40;
   localparam logic [6:0]  CAP_RST    = 7'h00;
   localparam logic [6:0]  CNT_SAT    = 7'h7F;
   localparam int unsigned CLK_HZ     = 40_000_000;
   localparam int unsigned TICK_S     = 1;
   localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_S;
   localparam logic [7:0]  TXPER_RST  = 8'h1E;
   localparam logic [3:0]  MAXREQ_RST = 4'h2;
   localparam logic [7:0]  A_CTRL     = 8'h00;
   localparam logic [7:0]  A_TXPER    = 8'h04;
   localparam logic [7:0]  A_MAXREQ   = 8'h08;
   localparam logic [7:0]  A_PSEL     = 8'h0C;
   localparam logic [7:0]  A_PCFG     = 8'h10;
   localparam logic [7:0]  A_PSTAT    = 8'h14;
   localparam int unsigned CTRL_CAP   = 0;
   localparam int unsigned CTRL_AUTH  = 1;
   localparam int unsigned CFG_LRNDIS = 7;
   localparam int unsigned CFG_MODE   = 8;
   localparam int unsigned ST_FULL    = 7;
   localparam int unsigned ST_AUTH    = 8;
   localparam int unsigned ST_LINK    = 9;
   localparam int unsigned ST_FSM     = 10;
   localparam logic [4:0]  PSEL_RST   = 5'h01;

   typedef enum logic [1:0] {
      PAF_NO_AUTH                     = 2'b00,
      PAF_FORCED_UNAUTHORIZED_SETTING = 2'b01,
      PAF_FORCED_AUTHORIZED_SETTING   = 2'b10,
      PAF_PORT_AUTH_AUTOMATIC_SETTING = 2'b11
   } paf_mode_t;
   localparam paf_mode_t MODE_RST = PAF_PORT_AUTH_AUTOMATIC_SETTING;

   typedef enum logic [2:0] {
      FK_DATA   = 3'b000,
      FK_START  = 3'b001,
      FK_LOGOFF = 3'b010,
      FK_EAP    = 3'b011,
      FK_OTHER  = 3'b100
   } paf_fkind_t;

   typedef enum logic [1:0] {
      SK_EAP    = 2'b00,
      SK_ACCEPT = 2'b01,
      SK_REJECT = 2'b10
   } paf_skind_t;

   typedef enum logic [1:0] {
      AS_IDLE = 2'b00,
      AS_REQ  = 2'b01,
      AS_SRV  = 2'b10,
      AS_AUTH = 2'b11
   } paf_ast_t;
endpackage

// ---- src/paf_auth_if.sv ----
// Signals between the filter core and one port's authenticator.
// Assumes all signals live on the core clock.
`timescale 1ns/1ps
interface paf_auth_if;
   logic                tick;
   logic                en;
   logic                link_up;
   paf_pkg::paf_mode_t  mode;
   logic [7:0]          tx_period;
   logic [3:0]          max_req;
   logic                ev_start;
   logic                ev_logoff;
   logic                ev_eap;
   logic                srv_accept;
   logic                srv_reject;
   logic                authorized;
   logic                id_req;
   logic                retx;
   paf_pkg::paf_ast_t   state;
   modport ctl (output tick, en, link_up, mode, tx_period, max_req, ev_start,
                ev_logoff, ev_eap, srv_accept, srv_reject,
                input authorized, id_req, retx, state);
   modport fsm (input tick, en, link_up, mode, tx_period, max_req, ev_start,
                ev_logoff, ev_eap, srv_accept, srv_reject,
                output authorized, id_req, retx, state);
endinterface

// ---- src/paf_auth_port.sv ----
// Authenticator state machine of one switch port.
// Assumes a synchronised link level and a one-second tick.
`timescale 1ns/1ps
module paf_auth_port (
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   paf_auth_if.fsm    pif
);
   paf_pkg::paf_ast_t state_r;
   logic              link_d_r;
   logic              id_req_r;
   logic              retx_r;
   logic [7:0]        sec_r;
   logic [3:0]        tries_r;
   logic              expired;
   logic              last_try;

   assign expired  = pif.tick && (sec_r + 8'h01 >= pif.tx_period);
   assign last_try = (tries_r + 4'h1 >= pif.max_req);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         link_d_r <= 1'b0;
      else
         link_d_r <= pif.link_up;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r  <= paf_pkg::AS_IDLE;
         id_req_r <= 1'b0;
         retx_r   <= 1'b0;
         sec_r    <= 8'h00;
         tries_r  <= 4'h0;
      end
      else
      begin
         id_req_r <= 1'b0;
         retx_r   <= 1'b0;
         if (pif.tick && sec_r != 8'hFF)
            sec_r <= sec_r + 8'h01;
         if (!pif.en || pif.mode == paf_pkg::PAF_NO_AUTH
             || pif.mode == paf_pkg::PAF_FORCED_UNAUTHORIZED_SETTING)
            state_r <= paf_pkg::AS_IDLE;
         else if (pif.mode == paf_pkg::PAF_FORCED_AUTHORIZED_SETTING)
            state_r <= paf_pkg::AS_AUTH;
         else if (!pif.link_up || pif.ev_logoff)
            state_r <= paf_pkg::AS_IDLE;
         else
         begin
            unique case (state_r)
               paf_pkg::AS_IDLE:
                  if ((pif.link_up && !link_d_r) || pif.ev_start)
                  begin
                     id_req_r <= 1'b1;
                     state_r  <= paf_pkg::AS_REQ;
                     sec_r    <= 8'h00;
                     tries_r  <= 4'h0;
                  end
               paf_pkg::AS_REQ:
                  if (pif.ev_eap)
                  begin
                     state_r <= paf_pkg::AS_SRV;
                     sec_r   <= 8'h00;
                     tries_r <= 4'h0;
                  end
                  else if (pif.ev_start)
                  begin
                     id_req_r <= 1'b1;
                     sec_r    <= 8'h00;
                  end
                  else if (expired)
                  begin
                     if (last_try)
                        state_r <= paf_pkg::AS_IDLE;
                     else
                     begin
                        id_req_r <= 1'b1;
                        tries_r  <= tries_r + 4'h1;
                        sec_r    <= 8'h00;
                     end
                  end
               paf_pkg::AS_SRV:
                  if (pif.srv_accept)
                     state_r <= paf_pkg::AS_AUTH;
                  else if (pif.srv_reject)
                     state_r <= paf_pkg::AS_IDLE;
                  else if (pif.ev_start)
                  begin
                     id_req_r <= 1'b1;
                     state_r  <= paf_pkg::AS_REQ;
                     sec_r    <= 8'h00;
                     tries_r  <= 4'h0;
                  end
                  else if (pif.ev_eap)
                     sec_r <= 8'h00;
                  else if (expired)
                  begin
                     if (last_try)
                        state_r <= paf_pkg::AS_IDLE;
                     else
                     begin
                        retx_r  <= 1'b1;
                        tries_r <= tries_r + 4'h1;
                        sec_r   <= 8'h00;
                     end
                  end
               paf_pkg::AS_AUTH:
                  if (pif.ev_start)
                  begin
                     id_req_r <= 1'b1;
                     state_r  <= paf_pkg::AS_REQ;
                     sec_r    <= 8'h00;
                     tries_r  <= 4'h0;
                  end
            endcase
         end
      end
   end

   assign pif.authorized = (state_r == paf_pkg::AS_AUTH);
   assign pif.id_req     = id_req_r;
   assign pif.retx       = retx_r;
   assign pif.state      = state_r;
endmodule

// ---- tb/paf_srv_model.sv ----
// Authentication server model answering relayed client payloads.
// Assumes relay requests arrive as one-cycle pulses on the core clock.
`timescale 1ns/1ps
module paf_srv_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       rly_i,
   input  wire logic [4:0] port_i,
   input  wire logic [1:0] kind_i,
   output logic            srv_valid_o,
   output logic      [4:0] srv_port_o,
   output logic      [1:0] srv_kind_o
);
   // Idle lines toggle so stale values never look valid
   always_ff @(posedge clk_i)
   begin
      srv_valid_o <= !rst_i && rly_i;
      srv_port_o  <= rst_i ? 5'h00 : (rly_i ? port_i : ~srv_port_o);
      srv_kind_o  <= rst_i ? 2'h0 : (rly_i ? kind_i : ~srv_kind_o);
   end
endmodule

// ---- tb/paf_checker.sv ----
// Assertions on the port access filter ports.
// Bound to the filter top; one clock, synchronous reset.
`timescale 1ns/1ps
module paf_checker (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   input wire logic       frm_valid_i,
   input wire logic [4:0] frm_port_i,
   input wire logic [2:0] frm_kind_i,
   input wire logic       dec_valid_o,
   input wire logic [4:0] dec_port_o,
   input wire logic       dec_fwd_o,
   input wire logic       dec_learn_o,
   input wire logic       dec_to_srv_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence wb_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   logic frm_ok;
   assign frm_ok = frm_valid_i && frm_port_i inside {[5'h01:5'h1A]};
   sequence frm_ok_s;
      frm_ok;
   endsequence
   wb_ack_next_a: assert property (wb_req_s |=> wb_ack_o)
      else $error("ack missing");
   wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   dec_answer_a: assert property (frm_ok_s |=>
      dec_valid_o && dec_port_o == $past(frm_port_i)) else $error("decision missing");
   dec_refuse_a: assert property (frm_valid_i && !frm_ok |=> !dec_valid_o)
      else $error("bad port answered");
   dec_spur_a: assert property (dec_valid_o |-> $past(frm_valid_i))
      else $error("decision without frame");
   auth_no_fwd_a: assert property (frm_ok && frm_kind_i != 3'h0 |=>
      !dec_fwd_o && !dec_learn_o) else $error("auth frame forwarded");
   srv_only_eap_a: assert property (frm_valid_i && frm_kind_i != 3'h3 |=>
      !dec_to_srv_o) else $error("bad relay");
   learn_fwd_a: assert property (dec_valid_o && dec_learn_o |-> dec_fwd_o)
      else $error("learn without forward");
endmodule
bind paf_port_access_filter paf_checker i_paf_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .frm_valid_i, .frm_port_i, .frm_kind_i, .dec_valid_o, .dec_port_o, .dec_fwd_o,
   .dec_learn_o, .dec_to_srv_o);

// ---- tb/testbench.sv ----
// Self-checking bench of the port access filter.
// Assumes the filter, server model and checker compile first.
`timescale 1ns/1ps
module testbench;
   logic        clk_i, rst_i, cyc, stb, we, ack, fv, kn, dv, df, dl, ds, agv, sv, ev, ep, cv;
   logic [1:0]  sk, skd;
   logic [2:0]  fk;
   logic [3:0]  sel;
   logic [4:0]  fp, dp, agp, sp, p, cp;
   logic [7:0]  adr;
   logic [25:0] link, idr, srx;
   logic [31:0] wd, rdat, rd;
   int          n_fail, n_compared, ncyc, cnt, seed;
   logic [7:0]  ra [5] = '{paf_pkg::A_TXPER, paf_pkg::A_MAXREQ, paf_pkg::A_PCFG,
                           paf_pkg::A_PSTAT, 8'h18};
   logic [31:0] rv [5] = '{32'h1E, 32'h2, 32'h300, 32'h0, 32'h0};
   paf_port_access_filter #(.SEC_CYCLES(20)) i_paf_port_access_filter (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
      .link_up_i(link), .frm_valid_i(fv), .frm_port_i(fp), .frm_kind_i(fk),
      .frm_sa_known_i(kn), .dec_valid_o(dv), .dec_port_o(dp), .dec_fwd_o(df),
      .dec_learn_o(dl), .dec_to_srv_o(ds), .eg_valid_i(fv), .eg_port_i(fp),
      .eg_eapol_i(fk != 3'h0), .eg_valid_o(ev), .eg_pass_o(ep), .age_valid_i(agv),
      .age_port_i(agp), .srv_valid_i(sv), .srv_port_i(sp), .srv_kind_i(skd),
      .cli_valid_o(cv), .cli_port_o(cp), .id_req_o(idr), .srv_retx_o(srx));
   paf_srv_model i_paf_srv_model (.clk_i(clk_i), .rst_i(rst_i), .rly_i(dv && ds),
      .port_i(dp), .kind_i(sk), .srv_valid_o(sv), .srv_port_o(sp), .srv_kind_o(skd));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hF};
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic frm(input logic [4:0] pt, input logic [2:0] k, input logic known);
      @(posedge clk_i);
      {fv, fp, fk, kn} <= {1'b1, pt, k, known};
      @(posedge clk_i);
      fv <= 1'b0;
      #1;
   endtask
   task automatic idw(input logic [4:0] pt, input logic rt);
      int n;
      n = 0;
      while (n < 30 && (rt ? srx[pt - 5'h01] : idr[pt - 5'h01]) !== 1'b1)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      check(n < 30, 1'b1, "pulse wait");
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      ncyc++;
      if (ncyc == 4000)
      begin
         n_fail++;
         final_report;
      end
   end
   initial
   begin
      {rst_i, cyc, stb, we, fv, kn, agv, sk, fk, sel, fp, agp, adr, link, wd} = '0;
      rst_i = 1'b1;
      seed = 45360;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ra[i])
      begin
         wb(1'b0, ra[i], 32'h0);
         check(rd, rv[i], "reset value");
      end
      p = 5'(1 + $unsigned($random(seed)) % 26);
      wb(1'b1, paf_pkg::A_CTRL, 32'h1);
      wb(1'b1, paf_pkg::A_PSEL, 32'(p));
      wb(1'b1, paf_pkg::A_PCFG, 32'h302);
      wb(1'b1, paf_pkg::A_PCFG, 32'h341);
      wb(1'b0, paf_pkg::A_PCFG, 32'h0);
      check(rd, 32'h302, "cap setting");
      repeat (3)
      begin
         frm(p, 3'h0, 1'b0);
         check({df, dl}, {2{cnt < 2}}, "learn");
         if (cnt < 2)
            cnt++;
      end
      frm(p, 3'h0, 1'b1);
      check(df, 1'b1, "known fwd");
      wb(1'b0, paf_pkg::A_PSTAT, 32'h0);
      check(rd[7:0], 8'h80 | 8'(cnt), "cap state");
      @(posedge clk_i);
      {agv, agp} <= {1'b1, p};
      @(posedge clk_i);
      agv <= 1'b0;
      frm(p, 3'h0, 1'b0);
      check(dl, 1'b1, "relearn");
      wb(1'b1, paf_pkg::A_CTRL, 32'h0);
      repeat (3) frm(p, 3'h1, 1'b0);
      frm(p, 3'h0, 1'b0);
      check(df, 1'b1, "cap off");
      frm(p, 3'h3, 1'b0);
      check({df, ds}, 2'b00, "auth off");
      wb(1'b1, paf_pkg::A_CTRL, 32'h2);
      frm(p, 3'h0, 1'b1);
      check({df, ev, ep}, 3'b010, "unauth drop");
      @(posedge clk_i);
      link[p - 5'h01] <= 1'b1;
      idw(p, 1'b0);
      for (int r = 1; r < 3; r++)
      begin
         sk <= 2'(3 - r);
         frm(p, 3'h1, 1'b0);
         idw(p, 1'b0);
         frm(p, 3'h3, 1'b0);
         check({ds, ev, ep}, 3'b111, "relay");
         repeat (2) @(posedge clk_i);
         #1;
         check({cv, cp}, {1'b1, p}, "to client");
         frm(p, 3'h0, 1'b1);
         check({df, ev, ep}, {1'(r - 1), 1'b1, 1'(r - 1)}, "verdict");
      end
      frm(p, 3'h2, 1'b0);
      frm(p, 3'h0, 1'b1);
      check({df, ep}, 2'b00, "logoff");
      sk <= 2'h0;
      wb(1'b1, paf_pkg::A_TXPER, 32'h1);
      frm(p, 3'h1, 1'b0);
      frm(p, 3'h3, 1'b0);
      idw(p, 1'b1);
      repeat (20) @(posedge clk_i);
      wb(1'b0, paf_pkg::A_PSTAT, 32'h0);
      check(rd[11:8], 4'h2, "gave up");
      final_report;
   end
endmodule
